// ==== sems_event_ctrl.sv ====
// Event flags, interrupt mask, decimation selects and auto mode switch.
//
// Operation
// [R1] Gesture decimation code picks 1..32, others 32.
// [R2] Eight-bit mask, set bit suppresses, resets ones.
// [R3] Mask bits: four proximity, gesture, sample, watchdog, FIFO.
// [R4] Flags latch events; write one clears them.
// [R5] Flag bits follow the mask bit order.
// [R6] FIFO event when entries exceed threshold.
// [R7] Auto switch on level-2 enter after storing.
// [R8] Proximity decimation code picks 1..32, others 32.
// [R9] Interrupt active while any unmasked flag set.
`timescale 1ns/1ps
`default_nettype none
module sems_event_ctrl
    import sems_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [15:0] regRdata,
    input  wire logic [6:0]  eventIn,
    input  wire logic [7:0]  fifoCount,
    input  wire logic        fifoStoreDone,
    input  wire logic        sampleIn,
    output logic             sampleOut,
    output logic      [5:0]  decFactor,
    output logic      [1:0]  opMode,
    output logic             intOut
);

    logic [7:0]  mask_reg;       // Interrupt mask, one means suppressed.
    logic [7:0]  flags_reg;      // Sticky event flags.
    logic [7:0]  flags_next;     // Next value of the flags.
    logic [2:0]  proxDec_reg;    // Proximity decimation select.
    logic [2:0]  gestDec_reg;    // Gesture decimation select.
    logic [3:0]  fifoTh_reg;     // FIFO level threshold.
    logic [1:0]  opMode_reg;     // Operating mode.
    logic        autoSw_reg;     // Auto switch enable.
    logic        switchPend_reg; // Level-2 enter seen, waiting for storing to end.
    logic        fifoAbove_reg;  // FIFO level was above threshold last cycle.
    logic        fifoAbove;      // FIFO level above threshold now.
    logic [7:0]  evSet;          // Events arriving this cycle.
    logic [7:0]  w1c;            // Flags cleared by a host write this cycle.
    logic        doSwitch;       // Move to gesture mode this cycle.
    logic [15:0] rdata_reg;      // Registered read data.
    logic        int_reg;        // Registered interrupt line.
    logic        sampleOut_reg;  // Registered kept-sample pulse.
    logic [5:0]  factor_reg;     // Registered decimation factor.

    sems_dec_if decBus ();

    // Decimator picks its code from the mode in force.
    sems_decimator sems_decimator_inst (
        .clk   (clk),
        .rst_b (rst_b),
        .dec   (decBus.dec)
    );

    // Proximity mode uses its own select; other modes use the gesture select.
    assign decBus.sampleIn = sampleIn;
    assign decBus.code = (opMode_reg == MODE_PROX) ? proxDec_reg : gestDec_reg;  // [R1] [R8]

    // The FIFO event fires when the level first rises above the threshold.
    assign fifoAbove = fifoCount > {4'h0, fifoTh_reg};  // [R6]

    // Gather events in flag order; the FIFO event is the top bit.
    always_comb begin
        evSet = {fifoAbove && !fifoAbove_reg, eventIn};  // [R5] [R6]
        w1c = 8'h00;
        if (regWrite && regAddr == EVENT_FLAGS_OFS) begin
            w1c = regWdata[7:0];  // [R4]
        end
        // A new event beats a clear in the same cycle.
        flags_next = (flags_reg & ~w1c) | evSet;  // [R4]
    end

    // Sticky flags, reset to zero.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Nothing is pending after reset.
            flags_reg <= FLAGS_RESET;
        end else begin
            // Host clears and new events land in the same update.
            flags_reg <= flags_next;  // [R4]
        end
    end

    // Track the FIFO comparison for edge detection.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Starts low like an empty FIFO, so no false edge follows reset.
            fifoAbove_reg <= 1'b0;
        end else begin
            // Without this history a cleared FIFO flag would be set again at once.
            fifoAbove_reg <= fifoAbove;
        end
    end

    // Mask register, all ones after reset.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Every event starts out suppressed.
            mask_reg <= MASK_RESET;  // [R2]
        end else if (regWrite && regAddr == EVENT_MASK_OFS) begin
            // Only the low byte is stored; the upper byte is reserved.
            mask_reg <= regWdata[7:0];  // [R2] [R3]
        end
    end

    // Configuration registers; reserved bits are not stored.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            proxDec_reg <= DEC_RESET;
            gestDec_reg <= DEC_RESET;
            fifoTh_reg  <= FIFO_LEVEL_THRESHOLD_RESET;
            autoSw_reg  <= 1'b0;
        end else if (regWrite) begin
            case (regAddr)
                DEC_CTRL_OFS: begin
                    // Both selects share one word; the bits between them are not kept.
                    proxDec_reg <= regWdata[PROX_DEC_LSB +: 3];  // [R8]
                    gestDec_reg <= regWdata[GEST_DEC_LSB +: 3];  // [R1]
                end
                FIFO_CFG_OFS: begin
                    // Only the threshold field of this word lives in this block.
                    fifoTh_reg <= regWdata[FIFO_LEVEL_THRESHOLD_LSB +: 4];  // [R6]
                end
                MODE_CTRL_OFS: begin
                    // The mode field of this word is stored by the mode process.
                    autoSw_reg <= regWdata[AUTO_SW_BIT];
                end
                default: begin
                    // Other addresses leave the configuration alone.
                end
            endcase
        end
    end

    // A pending switch completes once storing of the current package is done.
    assign doSwitch = autoSw_reg && (opMode_reg == MODE_PROX)
                      && (switchPend_reg || evSet[EV_ENTER2]) && fifoStoreDone;  // [R7]

    // Remember a level-2 enter until the switch happens or is called off.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            switchPend_reg <= 1'b0;
        end else if (doSwitch || !autoSw_reg || opMode_reg != MODE_PROX) begin
            // A stale request must not fire after the host changes the setup.
            switchPend_reg <= 1'b0;
        end else if (evSet[EV_ENTER2]) begin
            // Storing is still busy, so hold the request.
            switchPend_reg <= 1'b1;  // [R7]
        end
    end

    // Operating mode; a host write takes priority over the automatic switch.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            opMode_reg <= OPERATING_MODE_SELECT_RESET;
        end else if (regWrite && regAddr == MODE_CTRL_OFS) begin
            // The host always gets the mode it wrote.
            opMode_reg <= regWdata[OPERATING_MODE_SELECT_LSB +: 2];
        end else if (doSwitch) begin
            // Automatic move from proximity to sample/gesture mode.
            opMode_reg <= MODE_GESTURE;  // [R7]
        end
    end

    // Interrupt follows any flag whose mask bit is clear.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // No flag is set after reset, so the line starts released.
            int_reg <= 1'b0;
        end else begin
            // Uses the next flags so the line moves with the flag itself.
            int_reg <= |(flags_next & ~mask_reg);  // [R9] [R2]
        end
    end

    // Register decimator answers so data outputs come from flops.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sampleOut_reg <= 1'b0;
            factor_reg    <= FACTOR_RESET;
        end else begin
            // Both answers lag the decimator by one cycle.
            sampleOut_reg <= decBus.decOut;
            factor_reg    <= decBus.factor;
        end
    end

    // Read data is presented one cycle after the read strobe.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= RDATA_RESET;
        end else if (regRead) begin
            case (regAddr)
                // Mask in the low byte, reserved bits read zero.
                EVENT_MASK_OFS:  rdata_reg <= {8'h00, mask_reg};
                // Flags as they stood before this edge.
                EVENT_FLAGS_OFS: rdata_reg <= {8'h00, flags_reg};
                // Both decimation selects with the gap bit at zero.
                DEC_CTRL_OFS:    rdata_reg <= {9'h000, gestDec_reg, 1'b0, proxDec_reg};
                // Threshold in its own field, the rest zero.
                FIFO_CFG_OFS:    rdata_reg <= {4'h0, fifoTh_reg, 8'h00};
                // Auto switch enable and operating mode.
                MODE_CTRL_OFS:   rdata_reg <= {5'h00, autoSw_reg, 8'h00, opMode_reg};
                // Unmapped addresses read zero.
                default:         rdata_reg <= 16'h0000;
            endcase
        end
    end

    // Every output comes straight from its register.
    assign regRdata  = rdata_reg;
    assign intOut    = int_reg;
    assign sampleOut = sampleOut_reg;
    assign decFactor = factor_reg;
    assign opMode    = opMode_reg;

endmodule
`default_nettype wire

// ==== sems_pkg.sv ====
// Constants shared by the sensor event mask/status block and its decimator.
package sems_pkg;

    // Register offsets on the register access port.
    localparam logic [7:0]  FIFO_CFG_OFS     = 8'h1f;  // Holds the FIFO level threshold.
    localparam logic [7:0]  MODE_CTRL_OFS    = 8'h45;  // Operating mode and auto switch.
    localparam logic [7:0]  DEC_CTRL_OFS     = 8'h46;  // Decimation selects.
    localparam logic [7:0]  EVENT_MASK_OFS   = 8'h48;  // Interrupt mask.
    localparam logic [7:0]  EVENT_FLAGS_OFS  = 8'h49;  // Sticky event flags.

    // Field positions.
    localparam int          FIFO_LEVEL_THRESHOLD_LSB      = 8;      // fifo_level_threshold lowest bit.
    localparam int          AUTO_SW_BIT      = 10;     // auto_switch_to_gesture bit.
    localparam int          OPERATING_MODE_SELECT_LSB      = 0;      // operating_mode_select lowest bit.
    localparam int          PROX_DEC_LSB     = 0;      // proximity_decimation_select lowest bit.
    localparam int          GEST_DEC_LSB     = 4;      // gesture_decimation_select lowest bit.

    // Event bit positions, shared by mask and flags.
    localparam int          EV_ENTER1        = 0;      // prox_enter_level1.
    localparam int          EV_LEAVE1        = 1;      // prox_leave_level1.
    localparam int          EV_ENTER2        = 2;      // prox_enter_level2.
    localparam int          EV_LEAVE2        = 3;      // prox_leave_level2.
    localparam int          EV_GESTURE       = 4;      // Gesture event.
    localparam int          EV_SAMPLE        = 5;      // Sample event.
    localparam int          EV_WATCHDOG      = 6;      // Watchdog event.
    localparam int          EV_FIFO          = 7;      // FIFO above threshold.

    // Values after reset.
    localparam logic [7:0]  MASK_RESET       = 8'hff;  // All events masked.
    localparam logic [7:0]  FLAGS_RESET      = 8'h00;  // No events pending.
    localparam logic [2:0]  DEC_RESET        = 3'h0;   // Decimate by one.
    localparam logic [3:0]  FIFO_LEVEL_THRESHOLD_RESET    = 4'h0;   // Threshold zero.
    localparam logic [1:0]  OPERATING_MODE_SELECT_RESET    = 2'h0;   // Idle mode.
    localparam logic [5:0]  FACTOR_RESET     = 6'h01;  // Factor of one before any update.
    localparam logic [15:0] RDATA_RESET      = 16'h0000; // Read data before the first read.

    // Operating mode codes.
    localparam logic [1:0]  MODE_PROX        = 2'h1;   // Proximity mode.
    localparam logic [1:0]  MODE_GESTURE     = 2'h2;   // Sample/gesture mode.

    // Highest decimation code with its own rate; above it the rate stays at 32.
    localparam logic [2:0]  DEC_MAX_CODE     = 3'h5;
    localparam logic [4:0]  DEC_CNT_RESET    = 5'h00;  // Decimation counter start.

endpackage

// ==== sems_dec_if.sv ====
// Interface between the event block and its decimator.
`timescale 1ns/1ps
`default_nettype none
interface sems_dec_if;
    logic       sampleIn;   // One-cycle pulse per produced sample.
    logic [2:0] code;       // Active decimation select code.
    logic       decOut;     // One-cycle pulse per kept sample.
    logic [5:0] factor;     // Decimation factor in force.

    // Controller side drives the samples and the code.
    modport ctrl (output sampleIn, output code, input decOut, input factor);
    // Decimator side answers with kept samples.
    modport dec (input sampleIn, input code, output decOut, output factor);
endinterface
`default_nettype wire

// ==== sems_decimator.sv ====
// Decimator that keeps one sample out of a power-of-two count.
`timescale 1ns/1ps
`default_nettype none
module sems_decimator
    import sems_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    sems_dec_if.dec   dec
);

    logic [2:0] effCode;   // Code limited to the highest distinct rate.
    logic [4:0] cnt_reg;   // Samples seen since the last kept one.
    logic [4:0] lastCnt;   // Count value at which a sample is kept.

    // Codes above five fall back to the rate of 32.
    always_comb begin
        effCode = (dec.code > DEC_MAX_CODE) ? DEC_MAX_CODE : dec.code;  // [R1] [R8]
        lastCnt = 5'((6'h01 << effCode) - 6'h01);
        dec.factor = 6'h01 << effCode;
    end

    // Count samples and wrap at the chosen factor.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= DEC_CNT_RESET;
        end else if (dec.sampleIn) begin
            if (cnt_reg >= lastCnt) begin
                cnt_reg <= DEC_CNT_RESET;
            end else begin
                cnt_reg <= cnt_reg + 5'h01;
            end
        end
    end

    // A kept sample leaves in the same cycle as the one that completes the count.
    assign dec.decOut = dec.sampleIn && (cnt_reg >= lastCnt);

endmodule
`default_nettype wire

// ==== sems_host_model.sv ====
// Host model driving the register access port.
`timescale 1ns/1ps
`default_nettype none
module sems_host_model (
    input  wire logic        clk,
    output logic      [7:0]  regAddr,
    output logic      [15:0] regWdata,
    output logic             regWrite,
    output logic             regRead,
    input  wire logic [15:0] regRdata
);
    // Strobes idle low from time zero.
    initial begin
        regAddr = 8'h00;
        regWdata = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // Single write; released lines show inverted data so stale values never look valid.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask
    // Single read; data is registered at the sampling edge.
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        regAddr <= ~a;
        #1 d = regRdata;
    endtask
endmodule
`default_nettype wire

// ==== sems_event_ctrl_assertions.sv ====
// Port-level checks for the event block.
`timescale 1ns/1ps
`default_nettype none
module sems_event_ctrl_assertions
    import sems_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [7:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [15:0] regRdata,
    input wire logic [6:0]  eventIn,
    input wire logic [7:0]  fifoCount,
    input wire logic        fifoStoreDone,
    input wire logic        sampleIn,
    input wire logic        sampleOut,
    input wire logic [5:0]  decFactor,
    input wire logic [1:0]  opMode,
    input wire logic        intOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic cause;       // Anything that may set a flag or unmask one.
    logic maskTouched; // Mask written since reset.
    assign cause = regWrite || (|eventIn) || (fifoCount != 8'h00);
    // Remembers a mask write so the reset value can be checked.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) maskTouched <= 1'b0;
        else if (regWrite && regAddr == EVENT_MASK_OFS) maskTouched <= 1'b1;
    end
    property p_intRise; $rose(intOut) |-> $past(cause) || $past(cause, 2); endproperty
    a_intRise: assert property (p_intRise) else $error("interrupt rose alone");
    property p_intFall; $fell(intOut) |-> $past(regWrite) || $past(regWrite, 2); endproperty
    a_intFall: assert property (p_intFall) else $error("interrupt fell alone");
    property p_gest32; regWrite && regAddr == DEC_CTRL_OFS && regWdata[6:4] >= 3'h5
        && opMode != MODE_PROX |-> ##2 decFactor == 6'h20; endproperty
    a_gest32: assert property (p_gest32) else $error("gesture factor not 32");
    property p_prox32; regWrite && regAddr == DEC_CTRL_OFS && regWdata[2:0] >= 3'h5
        && opMode == MODE_PROX |-> ##2 decFactor == 6'h20; endproperty
    a_prox32: assert property (p_prox32) else $error("proximity factor not 32");
    property p_keep; sampleOut |-> $past(sampleIn); endproperty
    a_keep: assert property (p_keep) else $error("kept sample without input");
    property p_auto; opMode == MODE_GESTURE && $past(opMode) == MODE_PROX
        |-> $past(regWrite || fifoStoreDone); endproperty
    a_auto: assert property (p_auto) else $error("mode switched early");
    property p_resv; regRead && (regAddr == EVENT_MASK_OFS || regAddr == EVENT_FLAGS_OFS)
        |=> regRdata[15:8] == 8'h00; endproperty
    a_resv: assert property (p_resv) else $error("upper bits not zero");
    property p_maskRst; regRead && regAddr == EVENT_MASK_OFS && !maskTouched
        |=> regRdata[7:0] == MASK_RESET; endproperty
    a_maskRst: assert property (p_maskRst) else $error("mask reset value wrong");
endmodule
bind sems_event_ctrl sems_event_ctrl_assertions sems_event_ctrl_assertions_inst (.*);
`default_nettype wire

// ==== sems_event_ctrl_test.sv ====
// Self-checking bench for the event block.
`timescale 1ns/1ps
`default_nettype none
module sems_event_ctrl_test;
    import sems_pkg::*;
    logic        clk, rst_b, regWrite, regRead, fifoStoreDone, sampleIn, sampleOut, intOut;
    logic [7:0]  regAddr, fifoCount;
    logic [15:0] regWdata, regRdata, rv;
    logic [6:0]  eventIn;
    logic [5:0]  decFactor;
    logic [1:0]  opMode;
    logic [31:0] seed = 32'h3;
    int          failCount, checkCount, mm, mf, i, code, kept, w;
    sems_event_ctrl sems_event_ctrl_inst (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .eventIn(eventIn), .fifoCount(fifoCount), .fifoStoreDone(fifoStoreDone),
        .sampleIn(sampleIn), .sampleOut(sampleOut), .decFactor(decFactor),
        .opMode(opMode), .intOut(intOut));
    sems_host_model sems_host_model_inst (.clk(clk), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
    // Clock and kept-sample counter.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (sampleOut === 1'b1) kept++;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic testDone();
        $display("checks=%0d errors=%0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
        sems_host_model_inst.rd(a, rv);
        chk(rv, exp);
    endtask
    task automatic intChk();
        tick(1);
        chk(16'(intOut), 16'((mf & ~mm & 255) != 0));
    endtask
    // One-cycle event pulse, mirrored in the model flags.
    task automatic pulse(input logic [6:0] ev);
        @(posedge clk);
        eventIn <= ev;
        @(posedge clk);
        eventIn <= 7'h00;
        mf |= int'(ev);
    endtask
    task automatic samples(input int n);
        repeat (n) begin
            @(posedge clk);
            sampleIn <= 1'b1;
            @(posedge clk);
            sampleIn <= 1'b0;
        end
        tick(2);
    endtask
    // Watchdog sized well beyond the expected run.
    initial begin
        #2_000_000;
        failCount++;
        testDone();
    end
    initial begin
        rst_b = 1'b0;
        eventIn = 7'h00;
        fifoCount = 8'h00;
        fifoStoreDone = 1'b0;
        sampleIn = 1'b0;
        mm = 255;
        mf = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rdChk(EVENT_MASK_OFS, 16'h00ff);
        rdChk(EVENT_FLAGS_OFS, 16'h0000);
        for (i = 0; i < 7; i++) begin
            pulse(7'(1 << i) | 7'(xs()));
            intChk();
            mm = int'(xs() & 32'hff) & ~(1 << i);
            sems_host_model_inst.wr(EVENT_MASK_OFS, 16'(mm));
            intChk();
            rdChk(EVENT_FLAGS_OFS, 16'(mf));
            w = int'(xs() & 32'hff);
            sems_host_model_inst.wr(EVENT_FLAGS_OFS, 16'(w));
            mf &= ~w;
            intChk();
            rdChk(EVENT_FLAGS_OFS, 16'(mf));
        end
        sems_host_model_inst.wr(FIFO_CFG_OFS, 16'hf3ff);
        rdChk(FIFO_CFG_OFS, 16'h0300);
        @(posedge clk);
        fifoCount <= 8'h03;
        rdChk(EVENT_FLAGS_OFS, 16'(mf));
        @(posedge clk);
        fifoCount <= 8'h04;
        mf |= 128;
        rdChk(EVENT_FLAGS_OFS, 16'(mf));
        intChk();
        for (i = 0; i < 16; i++) begin
            if (i == 8) sems_host_model_inst.wr(MODE_CTRL_OFS, 16'h0001);
            sems_host_model_inst.wr(DEC_CTRL_OFS, 16'(((i & 7) << 4) | (7 - (i & 7))));
            code = (i < 8) ? (i & 7) : (7 - (i & 7));
            if (code > 5) code = 5;
            samples(32);
            kept = 0;
            samples(32);
            chk(16'(decFactor), 16'(1 << code));
            chk(16'(kept), 16'(32 >> code));
        end
        // Last loop pass left gesture select 7 and proximity select 0.
        rdChk(DEC_CTRL_OFS, 16'h0070);
        sems_host_model_inst.wr(MODE_CTRL_OFS, 16'h0401);
        pulse(7'h04);
        tick(2);
        chk(16'(opMode), 16'(MODE_PROX));
        @(posedge clk);
        fifoStoreDone <= 1'b1;
        tick(2);
        chk(16'(opMode), 16'(MODE_GESTURE));
        rdChk(MODE_CTRL_OFS, 16'h0402);
        rdChk(EVENT_FLAGS_OFS, 16'(mf));
        // A clear and a new event on the same edge: the event must win.
        fork
            sems_host_model_inst.wr(EVENT_FLAGS_OFS, 16'h0020);
            pulse(7'h20);
        join
        rdChk(EVENT_FLAGS_OFS, 16'(mf));
        rdChk(8'h00, 16'h0000);
        testDone();
    end
endmodule
`default_nettype wire
